// ### hw/agc_gain_loop.sv
// Receive gain loop: forward gain, CORDIC magnitude, loop filter, host port
`timescale 1ns/100ps
`default_nettype none
`include "agc_consts.svh"

module agc_gain_loop (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic in_valid,
  input wire logic signed [15:0] in_i,
  input wire logic signed [15:0] in_q,
  input wire logic interval_run,
  input wire logic sync_load_input,
  output logic out_valid,
  output logic signed [15:0] out_i,
  output logic signed [15:0] out_q,
  output logic [15:0] out_gain,
  output logic [17:0] gain_word
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Coarse shift by top nibble, fine multiply by 1.14 factor, saturate
  function automatic logic signed [15:0] fwd_gain(input logic signed [15:0] x,
                                                  input logic [17:0] g);
    logic signed [32:0] p;
    logic signed [48:0] s;
    p = x * $signed({1'b0, 2'b01, g[13:0]});
    s = {{16{p[32]}}, p} <<< g[17:14];
    s = s >>> 14;
    if (s > 49'sh0_0000_0000_7fff) begin
      fwd_gain = 16'sh7fff;
    end else if (s < -49'sh0_0000_0000_8000) begin
      fwd_gain = -16'sh8000;
    end else begin
      fwd_gain = s[15:0];
    end
  endfunction : fwd_gain

  // Float form: exponent nibble, mantissa with leading one dropped
  function automatic logic [15:0] gain_float(input logic [17:0] g);
    gain_float = {g[17:14], g[13:2]};
  endfunction : gain_float

  // Saturate a signed sum into the accumulator, then apply limits
  function automatic logic [25:0] clamp_acc(input logic signed [27:0] sum,
                                            input logic [17:0] lo,
                                            input logic [17:0] hi);
    logic [25:0] v;
    if (sum < 28'sh0) begin
      v = 26'h0;
    end else if (sum > 28'sh3ff_ffff) begin
      v = 26'h3ff_ffff;
    end else begin
      v = sum[25:0];
    end
    if (v[25:8] < lo) begin
      v = {lo, 8'h00};
    end else if (v[25:8] > hi) begin
      v = {hi, 8'h00};
    end
    clamp_acc = v;
  endfunction : clamp_acc

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d;
  logic [19:0] setpt_q, setpt_d;
  logic [17:0] lim_lo_q, lim_lo_d;
  logic [17:0] lim_hi_q, lim_hi_d;
  logic [7:0] lg_q [0:3];
  logic [7:0] lg_d [0:3];
  logic [17:0] hold_q, hold_d;
  logic [17:0] cap_q, cap_d;
  logic [31:0] rdata_q, rdata_d;
  logic sync1_q, sync2_q, sync3_q;
  agc_pkg::agc_cst_e cst_q, cst_d;
  logic [3:0] k_q, k_d;
  logic signed [19:0] cx_q, cx_d, cy_q, cy_d;
  logic [19:0] mag_q, mag_d;
  logic done_q, done_d;
  logic [25:0] acc_q, acc_d;
  logic signed [15:0] dly_i_q [0:`AGC_DLY_LEN-1];
  logic signed [15:0] dly_q_q [0:`AGC_DLY_LEN-1];
  logic signed [15:0] dly_i_d [0:`AGC_DLY_LEN-1];
  logic signed [15:0] dly_q_d [0:`AGC_DLY_LEN-1];
  logic out_valid_d;
  logic signed [15:0] out_i_d, out_q_d;
  logic [15:0] out_gain_d;

  agc_pkg::agc_mode_e mode;
  logic [17:0] gain;
  logic delayed;
  logic cmd_load, cmd_sample, sync_edge;
  logic signed [15:0] loop_i, loop_q;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------

  // Accumulator integer part is the forward gain word
  assign mode = agc_pkg::agc_mode_e'(ctrl_q[`AGC_CTRL_MODE_LSB +: 2]);
  assign gain = acc_q[25:8];
  assign gain_word = acc_q[25:8];
  assign delayed = (mode == agc_pkg::agc_m_sampled) || ctrl_q[`AGC_CTRL_DLY];
  assign cmd_load = reg_wr && (reg_addr == `AGC_OFS_CMD) && reg_wdata[`AGC_CMD_LOAD];
  assign cmd_sample = reg_wr && (reg_addr == `AGC_OFS_CMD) && reg_wdata[`AGC_CMD_SAMPLE];
  assign sync_edge = sync2_q && !sync3_q && ctrl_q[`AGC_CTRL_SYNC_EN];
  // Loop always sees the undelayed sample with the current gain
  assign loop_i = fwd_gain(in_i, gain);
  assign loop_q = fwd_gain(in_q, gain);

  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------

  // Writes, capture and read decode
  always_comb begin
    ctrl_d = ctrl_q;
    setpt_d = setpt_q;
    lim_lo_d = lim_lo_q;
    lim_hi_d = lim_hi_q;
    hold_d = hold_q;
    for (int n = 0; n < 4; n++) begin
      lg_d[n] = lg_q[n];
    end
    cap_d = cmd_sample ? gain : cap_q;
    if (reg_wr) begin
      if (reg_addr == `AGC_OFS_CTRL) begin
        ctrl_d = reg_wdata[7:0];
      end else if (reg_addr == `AGC_OFS_SETPT) begin
        setpt_d = reg_wdata[19:0];
      end else if (reg_addr == `AGC_OFS_LIM_LO) begin
        lim_lo_d = reg_wdata[17:0];
      end else if (reg_addr == `AGC_OFS_LIM_HI) begin
        lim_hi_d = reg_wdata[17:0];
      end else if (reg_addr[3:2] == 2'b10) begin
        lg_d[reg_addr[1:0]] = reg_wdata[7:0];
      end else if (reg_addr == `AGC_OFS_HOLD) begin
        hold_d = reg_wdata[17:0];
      end
    end
    rdata_d = 32'h0;
    if (reg_rd) begin
      if (reg_addr == `AGC_OFS_CTRL) begin
        rdata_d = {24'h0, ctrl_q};
      end else if (reg_addr == `AGC_OFS_SETPT) begin
        rdata_d = {12'h0, setpt_q};
      end else if (reg_addr == `AGC_OFS_LIM_LO) begin
        rdata_d = {14'h0, lim_lo_q};
      end else if (reg_addr == `AGC_OFS_LIM_HI) begin
        rdata_d = {14'h0, lim_hi_q};
      end else if (reg_addr == `AGC_OFS_RD_B0) begin
        rdata_d = {24'h0, cap_q[7:0]};
      end else if (reg_addr == `AGC_OFS_RD_B1) begin
        rdata_d = {24'h0, cap_q[15:8]};
      end else if (reg_addr == `AGC_OFS_RD_B2) begin
        rdata_d = {30'h0, cap_q[17:16]};
      end else if (reg_addr == `AGC_OFS_RD_FLT) begin
        rdata_d = {16'h0, gain_float(cap_q)};
      end else if (reg_addr[3:2] == 2'b10) begin
        rdata_d = {24'h0, lg_q[reg_addr[1:0]]};
      end else if (reg_addr == `AGC_OFS_HOLD) begin
        rdata_d = {14'h0, hold_q};
      end else if (reg_addr == `AGC_OFS_STAT) begin
        rdata_d = {13'h0, cst_q == agc_pkg::agc_c_run, gain};
      end
    end
  end

  // Register bank; loop gains reset to zero so the loop starts frozen
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= `AGC_RST_CTRL;
      setpt_q <= `AGC_RST_SETPT;
      lim_lo_q <= `AGC_RST_LIM_LO;
      lim_hi_q <= `AGC_RST_LIM_HI;
      hold_q <= 18'h0;
      cap_q <= 18'h0;
      rdata_q <= 32'h0;
      for (int n = 0; n < 4; n++) begin
        lg_q[n] <= 8'h00;
      end
    end else begin
      ctrl_q <= ctrl_d;
      setpt_q <= setpt_d;
      lim_lo_q <= lim_lo_d;
      lim_hi_q <= lim_hi_d;
      hold_q <= hold_d;
      cap_q <= cap_d;
      rdata_q <= rdata_d;
      for (int n = 0; n < 4; n++) begin
        lg_q[n] <= lg_d[n];
      end
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Load strobe synchroniser
  // ----------------------------------------------------------------

  // Pin comes from outside; third stage only feeds the edge detector
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= sync_load_input;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // ----------------------------------------------------------------
  // CORDIC magnitude
  // ----------------------------------------------------------------

  // Vectoring rotations; samples arriving while busy do not restart it
  always_comb begin
    cst_d = cst_q;
    k_d = k_q;
    cx_d = cx_q;
    cy_d = cy_q;
    mag_d = mag_q;
    done_d = 1'b0;
    case (cst_q)
      agc_pkg::agc_c_idle: begin
        if (in_valid && mode != agc_pkg::agc_m_bypass) begin
          cx_d = loop_i[15] ? -{{4{loop_i[15]}}, loop_i} : {{4{loop_i[15]}}, loop_i};
          cy_d = loop_q[15] ? -{{4{loop_q[15]}}, loop_q} : {{4{loop_q[15]}}, loop_q};
          k_d = 4'h0;
          cst_d = agc_pkg::agc_c_run;
        end
      end
      agc_pkg::agc_c_run: begin
        if (cy_q[19]) begin
          cx_d = cx_q - (cy_q >>> k_q);
          cy_d = cy_q + (cx_q >>> k_q);
        end else begin
          cx_d = cx_q + (cy_q >>> k_q);
          cy_d = cy_q - (cx_q >>> k_q);
        end
        k_d = k_q + 4'h1;
        if (k_q == `AGC_CORDIC_ITER - 4'h1) begin
          mag_d = cx_d;
          done_d = 1'b1;
          cst_d = agc_pkg::agc_c_idle;
        end
      end
      default: cst_d = agc_pkg::agc_c_idle;
    endcase
  end

  // Magnitude engine registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cst_q <= agc_pkg::agc_c_idle;
      k_q <= 4'h0;
      cx_q <= 20'sh0;
      cy_q <= 20'sh0;
      mag_q <= 20'h0;
      done_q <= 1'b0;
    end else begin
      cst_q <= cst_d;
      k_q <= k_d;
      cx_q <= cx_d;
      cy_q <= cy_d;
      mag_q <= mag_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // Loop filter
  // ----------------------------------------------------------------

  logic signed [20:0] err;
  logic set2, med;
  logic [7:0] lg_sel;
  logic signed [29:0] prod;
  logic signed [27:0] delta;

  // Error, gain set choice, scaled step and clamped accumulation
  always_comb begin
    err = $signed({1'b0, setpt_q}) - $signed({1'b0, mag_q});
    set2 = (mode == agc_pkg::agc_m_timed) && !interval_run;
    med = set2 ? ctrl_q[`AGC_CTRL_MED2] : ctrl_q[`AGC_CTRL_MED1];
    lg_sel = lg_q[{set2, err[20]}];
    prod = err * $signed({1'b0, lg_sel});
    if (med) begin
      delta = err[20] ? -$signed({16'h0, lg_sel, 4'h0})
                      : $signed({16'h0, lg_sel, 4'h0});
    end else begin
      delta = 28'(prod >>> `AGC_LG_SHIFT);
    end
    acc_d = acc_q;
    if (cmd_load || sync_edge) begin
      acc_d = clamp_acc($signed({2'b00, hold_q, 8'h00}), lim_lo_q, lim_hi_q);
    end else if (done_q) begin
      acc_d = clamp_acc($signed({2'b00, acc_q}) + delta, lim_lo_q, lim_hi_q);
    end
  end

  // Accumulator starts at unity gain
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_q <= 26'h0;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ----------------------------------------------------------------
  // Delay line and output
  // ----------------------------------------------------------------

  // Shift one place per sample; gain applies as samples leave the end
  always_comb begin
    for (int n = 0; n < `AGC_DLY_LEN; n++) begin
      dly_i_d[n] = dly_i_q[n];
      dly_q_d[n] = dly_q_q[n];
    end
    out_valid_d = in_valid;
    out_i_d = out_i;
    out_q_d = out_q;
    out_gain_d = out_gain;
    if (in_valid) begin
      dly_i_d[0] = in_i;
      dly_q_d[0] = in_q;
      for (int n = 1; n < `AGC_DLY_LEN; n++) begin
        dly_i_d[n] = dly_i_q[n-1];
        dly_q_d[n] = dly_q_q[n-1];
      end
      // Gain stays with its sample only here: no back end inside
      out_gain_d = ctrl_q[`AGC_CTRL_MON_CAP] ? gain_float(cap_q) : gain_float(gain);
      if (mode == agc_pkg::agc_m_bypass) begin
        out_i_d = in_i;
        out_q_d = in_q;
        out_gain_d = 16'h0;
      end else if (delayed) begin
        out_i_d = fwd_gain(dly_i_q[`AGC_DLY_LEN-1], gain);
        out_q_d = fwd_gain(dly_q_q[`AGC_DLY_LEN-1], gain);
      end else begin
        out_i_d = loop_i;
        out_q_d = loop_q;
      end
    end
  end

  // Output and delay registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_i <= 16'sh0;
      out_q <= 16'sh0;
      out_gain <= 16'h0;
      for (int n = 0; n < `AGC_DLY_LEN; n++) begin
        dly_i_q[n] <= 16'sh0;
        dly_q_q[n] <= 16'sh0;
      end
    end else begin
      out_valid <= out_valid_d;
      out_i <= out_i_d;
      out_q <= out_q_d;
      out_gain <= out_gain_d;
      for (int n = 0; n < `AGC_DLY_LEN; n++) begin
        dly_i_q[n] <= dly_i_d[n];
        dly_q_q[n] <= dly_q_d[n];
      end
    end
  end

endmodule : agc_gain_loop
`default_nettype wire

// ### hw/agc_consts.svh
// Constants of the gain loop: offsets, fields, reset values, widths
//
// Notes on behaviour
// - 18-bit gain, top four bits shift
// - Low 14 bits under 01 prefix multiply
// - I and Q saturate separately at full scale
// - Error is set point minus magnitude
// - Scaled error accumulates; accumulator is gain
// - Output above set point lowers gain
// - Accumulator clamped between programmable limits
// - Gain is unity or more, never less
// - CORDIC magnitude, one rotation per clock
// - Mean mode: step proportional to error
// - Median mode: fixed step by error sign
// - Separate loop gains for positive, negative error
// - Load via holding register, then transfer
// - Out-of-limit load clamps to nearest limit
// - Equal limits or zero gain hold
// - Sample command captures gain; read at 4-7
// - Monitor shows live or captured gain
// - Monitor gain aligned only without back end
// - Delay mode: loop undelayed, gain at exit
// - Continuous mode updates loop on each sample that arrives while CORDIC is idle
// - Bypass passes samples unchanged
// - Timed mode: set one while interval runs
// - Gain output 4-bit exponent, 12-bit mantissa
`ifndef AGC_CONSTS_SVH
`define AGC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (word index)
// ----------------------------------------------------------------
`define AGC_OFS_CTRL 4'h0
`define AGC_OFS_SETPT 4'h1
`define AGC_OFS_LIM_LO 4'h2
`define AGC_OFS_LIM_HI 4'h3
`define AGC_OFS_RD_B0 4'h4
`define AGC_OFS_RD_B1 4'h5
`define AGC_OFS_RD_B2 4'h6
`define AGC_OFS_RD_FLT 4'h7
`define AGC_OFS_LG_P1 4'h8
`define AGC_OFS_LG_N1 4'h9
`define AGC_OFS_LG_P2 4'ha
`define AGC_OFS_LG_N2 4'hb
`define AGC_OFS_HOLD 4'hc
`define AGC_OFS_CMD 4'hd
`define AGC_OFS_STAT 4'he

// ----------------------------------------------------------------
// Control fields, command bits, reset values
// ----------------------------------------------------------------
`define AGC_CTRL_MODE_LSB 0
`define AGC_CTRL_DLY 2
`define AGC_CTRL_MED1 3
`define AGC_CTRL_MED2 4
`define AGC_CTRL_SYNC_EN 5
`define AGC_CTRL_MON_CAP 6
`define AGC_CMD_LOAD 0
`define AGC_CMD_SAMPLE 1
`define AGC_RST_CTRL 8'h00
`define AGC_RST_SETPT 20'h04000
`define AGC_RST_LIM_LO 18'h00000
`define AGC_RST_LIM_HI 18'h3ffff

// ----------------------------------------------------------------
// Arithmetic shape
// ----------------------------------------------------------------
`define AGC_CORDIC_ITER 4'h8
`define AGC_LG_SHIFT 4
`define AGC_MED_SHIFT 4
`define AGC_ACC_FRAC 8
`define AGC_DLY_LEN 8

`endif

// ### hw/agc_pkg.sv
// Types shared by the gain loop
package agc_pkg;

  // Loop update mode
  typedef enum logic [1:0] {
    agc_m_bypass = 2'b00,
    agc_m_cont = 2'b01,
    agc_m_timed = 2'b10,
    agc_m_sampled = 2'b11
  } agc_mode_e;

  // Magnitude engine state
  typedef enum logic {
    agc_c_idle = 1'b0,
    agc_c_run = 1'b1
  } agc_cst_e;

endpackage : agc_pkg

// ### verif/agc_gain_loop_assertions.sv
// Port-level checker of the gain loop, bound to its top module
`timescale 1ns/100ps
`default_nettype none
`include "agc_consts.svh"
module agc_gain_loop_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic in_valid,
  input wire logic out_valid,
  input wire logic signed [15:0] out_i,
  input wire logic signed [15:0] out_q,
  input wire logic [17:0] gain_word
);
  // ----
  // Shadow of holding gain and limits
  // ----
  logic [17:0] hold_q, hold_d, lo_q, lo_d, hi_q, hi_d, load_exp;
  // Follow host writes so a load can be predicted
  always_comb begin
    hold_d = hold_q;
    lo_d = lo_q;
    hi_d = hi_q;
    if (reg_wr && reg_addr == `AGC_OFS_HOLD) hold_d = reg_wdata[17:0];
    if (reg_wr && reg_addr == `AGC_OFS_LIM_LO) lo_d = reg_wdata[17:0];
    if (reg_wr && reg_addr == `AGC_OFS_LIM_HI) hi_d = reg_wdata[17:0];
  end
  // Registers only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold_q <= 18'h00000;
      lo_q <= `AGC_RST_LIM_LO;
      hi_q <= `AGC_RST_LIM_HI;
    end else begin
      hold_q <= hold_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end
  // Lower limit wins when both are violated
  assign load_exp = (hold_q < lo_q) ? lo_q : ((hold_q > hi_q) ? hi_q : hold_q);
  // ----
  // Properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence load_cmd_s;
    reg_wr && reg_addr == `AGC_OFS_CMD && reg_wdata[`AGC_CMD_LOAD];
  endsequence
  sequence cap_rd_s;
    reg_rd && (reg_addr == `AGC_OFS_RD_B0 || reg_addr == `AGC_OFS_RD_B1);
  endsequence
  out_follow_a: assert property (in_valid |=> out_valid)
    else $error("no output pulse after a sample");
  out_pulse_a: assert property (!in_valid |=> !out_valid)
    else $error("output pulse without a sample");
  out_hold_a: assert property (!out_valid |-> $stable(out_i) && $stable(out_q))
    else $error("output sample moved between pulses");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside its cycle");
  rd_top_a: assert property (reg_rd && reg_addr == `AGC_OFS_RD_B2 |=> reg_rdata[31:2] == 30'h0)
    else $error("top gain bits too wide");
  rd_byte_a: assert property (cap_rd_s |=> reg_rdata[31:8] == 24'h0)
    else $error("gain byte too wide");
  load_clamp_a: assert property (load_cmd_s |=> gain_word == $past(load_exp))
    else $error("loaded gain wrong");
  reset_zero_a: assert property (@(posedge clk) disable iff (1'b0)
    !nrst |=> gain_word == 18'h0 && !out_valid && reg_rdata == 32'h0)
    else $error("outputs not cleared by reset");
endmodule : agc_gain_loop_chk
bind agc_gain_loop agc_gain_loop_chk u_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .in_valid(in_valid), .out_valid(out_valid), .out_i(out_i), .out_q(out_q),
  .gain_word(gain_word));
`default_nettype wire

// ### verif/agc_src_model.sv
// Upstream filter chain model: sends I/Q samples to the gain loop
`timescale 1ns/100ps
`default_nettype none
module agc_src_model #(
  parameter int GAP = 12
) (
  input wire logic clk,
  output var logic in_valid,
  output var logic signed [15:0] in_i,
  output var logic signed [15:0] in_q
);
  // Idle at time zero
  initial begin
    in_valid = 1'b0;
    in_i = 16'h0000;
    in_q = 16'h0000;
  end
  // One sample; the lead-in wait covers every mode and lets the loop settle
  task automatic send(input logic signed [15:0] i, input logic signed [15:0] q);
    repeat (GAP) @(posedge clk);
    in_valid <= 1'b1;
    in_i <= i;
    in_q <= q;
    @(posedge clk);
    in_valid <= 1'b0;
    in_i <= ~i;
    in_q <= ~q;
  endtask : send
endmodule : agc_src_model
`default_nettype wire

// ### verif/agc_gain_loop_tb_top.sv
// Self-checking bench of the gain loop
`timescale 1ns/100ps
`default_nettype none
`include "agc_consts.svh"
module agc_gain_loop_tb_top;
  logic clk, nrst, reg_wr, reg_rd, in_valid, interval_run, sync_load_input, out_valid;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic signed [15:0] in_i, in_q, out_i, out_q;
  logic [15:0] out_gain;
  logic [17:0] gain_word, gp;
  int err_total, checks_done;
  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  agc_gain_loop DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_i(in_i), .in_q(in_q), .interval_run(interval_run),
    .sync_load_input(sync_load_input), .out_valid(out_valid), .out_i(out_i),
    .out_q(out_q), .out_gain(out_gain), .gain_word(gain_word));
  agc_src_model src (.clk(clk), .in_valid(in_valid), .in_i(in_i), .in_q(in_q));
  // ----
  // Shared tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic gchk(input string nm, input logic [17:0] e);
    chk(nm, {14'h0, e}, {14'h0, gain_word});
  endtask : gchk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk(nm, e, rv);
  endtask : rchk
  task automatic ld(input logic [17:0] g);
    wr(`AGC_OFS_HOLD, {14'h0, g});
    wr(`AGC_OFS_CMD, 32'h1);
    cyc(1);
  endtask : ld
  task automatic smp(input logic signed [15:0] i, input logic signed [15:0] q);
    src.send(i, q);
    #1;
    chk("out_valid", 32'h1, {31'h0, out_valid});
  endtask : smp
  // Shift by the top nibble, multiply by 1.m, clip to full scale
  function automatic logic [15:0] fwd(input logic signed [15:0] x, input logic [17:0] g);
    longint v;
    // Signed factor 1.m: an unsigned operand would turn the shift logical
    v = ((longint'(x) * longint'({2'b01, g[13:0]})) >>> 14) <<< g[17:14];
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction : fwd
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rchk(`AGC_OFS_CTRL, 32'h0, "ctrl");
    rchk(`AGC_OFS_SETPT, 32'h4000, "setpoint");
    rchk(`AGC_OFS_LIM_HI, 32'h3ffff, "lim_hi");
    rchk(`AGC_OFS_LG_N2, 32'h0, "lg_n2");
    wr(4'hf, 32'hffffffff);
    rchk(4'hf, 32'h0, "unmapped");
    gchk("gain_rst", 18'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_bypass;
    ld(18'h04000);
    gchk("load", 18'h04000);
    smp(16'h04d2, 16'hffb3);
    chk("bypass", 32'h04d2ffb3, {out_i, out_q});
    chk("byp_gain", 32'h0, {16'h0, out_gain});
    $display("bypass test done");
  endtask : t_bypass
  task automatic t_fwd;
    logic [17:0] gt [4];
    gt = '{18'h00000, 18'h04000, 18'h06000, 18'h0c000};
    wr(`AGC_OFS_CTRL, 32'h1);
    for (int k = 0; k < 4; k++) begin
      ld(gt[k]);
      smp(16'h03e8, 16'hfc18);
      chk("fwd", {fwd(16'h03e8, gt[k]), fwd(16'hfc18, gt[k])}, {out_i, out_q});
    end
    ld(18'h3c000);
    smp(16'h0064, 16'h0000);
    chk("sat_pos", 32'h7fff0000, {out_i, out_q});
    smp(16'hff9c, 16'h0064);
    chk("sat_both", 32'h80007fff, {out_i, out_q});
    $display("forward test done");
  endtask : t_fwd
  task automatic t_read;
    ld(18'h2a5c3);
    wr(`AGC_OFS_CMD, 32'h2);
    rchk(`AGC_OFS_RD_B0, 32'hc3, "cap_b0");
    rchk(`AGC_OFS_RD_B1, 32'ha5, "cap_b1");
    rchk(`AGC_OFS_RD_B2, 32'h2, "cap_b2");
    rchk(`AGC_OFS_RD_FLT, 32'ha970, "cap_float");
    ld(18'h04000);
    wr(`AGC_OFS_CTRL, 32'h41);
    smp(16'h0001, 16'h0001);
    chk("mon_cap", 32'ha970, {16'h0, out_gain});
    wr(`AGC_OFS_CTRL, 32'h1);
    smp(16'h0001, 16'h0001);
    chk("mon_live", 32'h1000, {16'h0, out_gain});
    $display("read test done");
  endtask : t_read
  task automatic t_clamp;
    wr(`AGC_OFS_LIM_LO, 32'h1000);
    wr(`AGC_OFS_LIM_HI, 32'h8000);
    ld(18'h3ffff);
    gchk("clamp_hi", 18'h08000);
    ld(18'h00000);
    gchk("clamp_lo", 18'h01000);
    wr(`AGC_OFS_LIM_HI, 32'h1000);
    wr(`AGC_OFS_LG_P1, 32'h10);
    smp(16'h0010, 16'h0010);
    cyc(12);
    gchk("equal_lim", 18'h01000);
    wr(`AGC_OFS_LIM_HI, 32'h3ffff);
    wr(`AGC_OFS_LIM_LO, 32'h0);
    $display("clamp test done");
  endtask : t_clamp
  task automatic t_loop;
    wr(`AGC_OFS_CTRL, 32'h9);
    ld(18'h04000);
    smp(16'h0010, 16'h0010);
    cyc(12);
    gchk("median_step", 18'h04001);
    wr(`AGC_OFS_CTRL, 32'h1);
    smp(16'h0010, 16'h0010);
    cyc(12);
    chk("mean_rise", 32'h1, {31'h0, gain_word > 18'h04002});
    gp = gain_word;
    wr(`AGC_OFS_SETPT, 32'h0);
    smp(16'h1f40, 16'h1f40);
    cyc(12);
    gchk("neg_zero", gp);
    wr(`AGC_OFS_LG_N1, 32'h10);
    smp(16'h1f40, 16'h1f40);
    cyc(12);
    chk("fall", 32'h1, {31'h0, gain_word < gp});
    $display("loop test done");
  endtask : t_loop
  task automatic t_timed;
    wr(`AGC_OFS_SETPT, 32'h4000);
    wr(`AGC_OFS_CTRL, 32'h2);
    ld(18'h04000);
    smp(16'h0010, 16'h0010);
    cyc(12);
    gchk("set_two", 18'h04000);
    @(posedge clk);
    interval_run <= 1'b1;
    smp(16'h0010, 16'h0010);
    cyc(12);
    chk("set_one", 32'h1, {31'h0, gain_word > 18'h04000});
    gp = gain_word;
    @(posedge clk);
    interval_run <= 1'b0;
    // Set two in median mode: one fixed step up for a small signal
    wr(`AGC_OFS_LG_P2, 32'h10);
    wr(`AGC_OFS_CTRL, 32'h12);
    smp(16'h0010, 16'h0010);
    cyc(12);
    gchk("med_two", gp + 18'h1);
    rchk(`AGC_OFS_STAT, {14'h0, gp + 18'h1}, "status");
    $display("timed test done");
  endtask : t_timed
  task automatic t_delay;
    logic [31:0] md [2];
    md = '{32'h5, 32'h3};
    wr(`AGC_OFS_LG_P1, 32'h0);
    wr(`AGC_OFS_LG_N1, 32'h0);
    for (int m = 0; m < 2; m++) begin
      wr(`AGC_OFS_CTRL, md[m]);
      ld(18'h00000);
      for (int k = 0; k < 9; k++) begin
        smp(16'h0100 + 16'(k), 16'h0200 + 16'(k));
      end
      chk("delayed", 32'h01000200, {out_i, out_q});
    end
    $display("delay test done");
  endtask : t_delay
  task automatic t_sync;
    wr(`AGC_OFS_CTRL, 32'h21);
    wr(`AGC_OFS_HOLD, 32'h1234);
    @(posedge clk);
    sync_load_input <= 1'b1;
    for (int n = 0; n < 8 && gain_word !== 18'h01234; n++) cyc(1);
    gchk("sync_load", 18'h01234);
    if (gain_word !== 18'h01234) complete_run();
    @(posedge clk);
    sync_load_input <= 1'b0;
    $display("sync test done");
  endtask : t_sync
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    interval_run = 1'b0;
    sync_load_input = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_bypass();
    t_fwd();
    t_read();
    t_clamp();
    t_loop();
    t_timed();
    t_delay();
    t_sync();
    complete_run();
  end
  // Watchdog so a hang still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule : agc_gain_loop_tb_top
`default_nettype wire
